// >>> shared/acc_consts.vh
// Register indices, field positions, reset values and timing counts of the converter control
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_IDX_CTRL      8'h0a
`define ACC_IDX_AVG       8'h0c
`define ACC_IDX_SAMP      8'h0d
`define ACC_IDX_WINDOW_LOWER_THRESHOLD     8'h0e
`define ACC_IDX_WINDOW_UPPER_THRESHOLD     8'h10
`define ACC_IDX_GAIN      8'h12
`define ACC_IDX_OFFS      8'h14
`define ACC_IDX_TRIG      8'h18
`define ACC_IDX_SYNC      8'h20
`define ACC_IDX_RESULT    8'h24
`define ACC_CTRL_DIFF     0
`define ACC_CTRL_LEFT     1
`define ACC_CTRL_FREE     2
`define ACC_CTRL_CORR     3
`define ACC_CTRL_WMODE_LO 8
`define ACC_CTRL_WMODE_HI 10
`define ACC_CTRL_MASK     16'h373f
`define ACC_AVG_MASK      8'h7f
`define ACC_SAMP_MASK     8'hbf
`define ACC_SAMP_COMPARATOR_OFFSET_COMP  7
`define ACC_GAIN_RST      12'h000
`define ACC_TRIG_START    1
`define ACC_SB_CTRL       3
`define ACC_SB_AVG        4
`define ACC_SB_SAMP       5
`define ACC_SB_WINDOW_LOWER_THRESHOLD      6
`define ACC_SB_WINDOW_UPPER_THRESHOLD      7
`define ACC_SB_GAIN       8
`define ACC_SB_OFFS       9
`define ACC_SB_TRIG       10
`define ACC_CNT_MAX       4'ha
`define ACC_COMPARATOR_OFFSET_COMP_CYC   6'd3
`define ACC_CORR_CYC      6'd13
`define ACC_CONV_CYC      6'd12
`define ACC_PRESCALE      4'd4
`define ACC_WM_ABOVE      3'h1
`define ACC_WM_BELOW      3'h2
`define ACC_WM_INSIDE     3'h3
`define ACC_WM_OUTSIDE    3'h4
`endif

// >>> hw/acc_conv_ctrl.v
// Converter configuration, sequencing and result shaping with an APB register slave
//
// Functional notes
// R1: Correction enable applies gain and offset
// R2: Correction adds 13 converter clocks per conversion
// R3: Continuous bit restarts conversion after each finish
// R4: Justify bit selects right or left alignment
// R5: Differential bit converts positive minus negative input
// R6: Software polls sync flags after config writes
// R7: Division field shifts accumulated sum power-two
// R8: Count field sums two-power samples, max 1024
// R9: Software raises resolution when accumulating wide sums
// R10: Offset compensation fixes sampling at four clocks
// R11: Software never mixes offset compensation, sample length
// R12: Sampling lasts sample length plus one clocks
// R13: Lower threshold bounds window comparison
// R14: Window mode selects above, below, inside, outside; outside here hits only when upper threshold < result < lower threshold
// R15: Upper threshold bounds window comparison
// R16: Gain is one integer, eleven fraction bits
// R17: Offset correction is signed two's complement
// R18: Sum shifted right by division field
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "acc_consts.vh"
module acc_conv_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        start_trig,
  input  wire [11:0] conv_data,
  output reg         sampling_o,
  output reg         differential_o,
  output reg         result_valid_o,
  output reg         window_hit_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SAMP = 3'd1;
  localparam ST_CONV = 3'd2;
  localparam ST_CORR = 3'd3;
  localparam ST_ACC  = 3'd4;
  localparam ST_DONE = 3'd5;

  // Signed-or-unsigned limit of the corrected 12-bit value
  function [11:0] corr_fn;
    input [11:0] raw;
    input [11:0] gain;
    input [11:0] offs;
    input        diff;
    reg signed [13:0] d;
    reg signed [27:0] p;
    reg signed [27:0] q;
    begin
      d = $signed({{2{raw[11] & diff}}, raw}) - $signed({{2{offs[11]}}, offs}); // [R17]
      p = d * $signed({2'b00, gain});                                          // [R16]
      q = p >>> 11;                                                            // [R16]
      if (diff)
        corr_fn = (q > 28'sd2047) ? 12'h7ff : (q < -28'sd2048) ? 12'h800 : q[11:0];
      else
        corr_fn = (q > 28'sd4095) ? 12'hfff : (q < 28'sd0) ? 12'h000 : q[11:0];
    end
  endfunction

  function less_fn;
    input [15:0] a;
    input [15:0] b;
    input        sgn;
    begin
      less_fn = sgn ? ($signed(a) < $signed(b)) : (a < b);
    end
  endfunction

  // Shadow registers written by software, active copies used by the sequencer
  reg  [15:0] ctrl_s_r;
  reg  [7:0]  avg_s_r;
  reg  [7:0]  samp_s_r;
  reg  [15:0] window_lower_threshold_s_r;
  reg  [15:0] window_upper_threshold_s_r;
  reg  [11:0] gain_s_r;
  reg  [11:0] offs_s_r;
  reg  [15:0] ctrl_r;
  reg  [7:0]  avg_r;
  reg  [7:0]  samp_r;
  reg  [15:0] window_lower_threshold_r;
  reg  [15:0] window_upper_threshold_r;
  reg  [11:0] gain_r;
  reg  [11:0] offs_r;
  reg  [10:0] sync_r;
  reg  [10:0] sync_set;
  reg  [15:0] result_r;
  reg  [3:0]  pre_r;
  reg         tick_r;
  reg  [2:0]  st_r;
  reg  [5:0]  cnt_r;
  reg  [10:0] num_r;
  reg  [21:0] acc_r;
  reg  [11:0] raw_r;
  reg         start_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;
  reg  [21:0] sum_nxt;
  reg  [21:0] div_nxt;
  reg  [15:0] res_nxt;
  reg  [11:0] val_nxt;
  reg         win_nxt;
  wire [7:0]  idx    = {2'b00, paddr[7:2]};
  wire        wr_acc = psel & penable & pready & pwrite;
  wire        diff   = ctrl_r[`ACC_CTRL_DIFF];
  wire [2:0]  wmode  = ctrl_r[`ACC_CTRL_WMODE_HI:`ACC_CTRL_WMODE_LO];
  wire [3:0]  n_code = (avg_r[3:0] > `ACC_CNT_MAX) ? `ACC_CNT_MAX : avg_r[3:0];
  wire [10:0] n_last = (11'h001 << n_code) - 11'h001;
  // Offset compensation wins: sample length is only honoured with it cleared
  wire [5:0]  samp_last = samp_r[`ACC_SAMP_COMPARATOR_OFFSET_COMP] ? `ACC_COMPARATOR_OFFSET_COMP_CYC : samp_r[5:0]; // [R10] [R12]

  // Read mux and unmapped-address check
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (idx)
      `ACC_IDX_CTRL:   rd_nxt = {16'h0000, ctrl_s_r};
      `ACC_IDX_AVG:    rd_nxt = {24'h000000, avg_s_r};
      `ACC_IDX_SAMP:   rd_nxt = {24'h000000, samp_s_r};
      `ACC_IDX_WINDOW_LOWER_THRESHOLD:  rd_nxt = {16'h0000, window_lower_threshold_s_r};
      `ACC_IDX_WINDOW_UPPER_THRESHOLD:  rd_nxt = {16'h0000, window_upper_threshold_s_r};
      `ACC_IDX_GAIN:   rd_nxt = {20'h00000, gain_s_r};
      `ACC_IDX_OFFS:   rd_nxt = {20'h00000, offs_s_r};
      `ACC_IDX_TRIG:   rd_nxt = {30'h00000000, start_r, 1'b0};
      `ACC_IDX_SYNC:   rd_nxt = {21'h000000, sync_r};
      `ACC_IDX_RESULT: rd_nxt = {16'h0000, result_r};
      default:         err_nxt = 1'b1;
    endcase
    if (paddr[1:0] != 2'b00)
      err_nxt = 1'b1;
  end

  // Sync flags raised by accepted writes to the config registers and by trigger writes with the start bit set
  always @* begin
    sync_set = 11'h000;
    if (wr_acc && !pslverr) begin
      case (idx)
        `ACC_IDX_CTRL:  sync_set[`ACC_SB_CTRL]  = 1'b1;
        `ACC_IDX_AVG:   sync_set[`ACC_SB_AVG]   = 1'b1;
        `ACC_IDX_SAMP:  sync_set[`ACC_SB_SAMP]  = 1'b1;
        `ACC_IDX_WINDOW_LOWER_THRESHOLD: sync_set[`ACC_SB_WINDOW_LOWER_THRESHOLD] = 1'b1;
        `ACC_IDX_WINDOW_UPPER_THRESHOLD: sync_set[`ACC_SB_WINDOW_UPPER_THRESHOLD] = 1'b1;
        `ACC_IDX_GAIN:  sync_set[`ACC_SB_GAIN]  = 1'b1;
        `ACC_IDX_OFFS:  sync_set[`ACC_SB_OFFS]  = 1'b1;
        `ACC_IDX_TRIG:  sync_set[`ACC_SB_TRIG]  = pwdata[`ACC_TRIG_START];
        default:        sync_set = 11'h000;
      endcase
    end
  end

  // Result shaping: correction, accumulation, division, justification, window
  always @* begin
    val_nxt = ctrl_r[`ACC_CTRL_CORR] ? corr_fn(raw_r, gain_r, offs_r, diff) : raw_r; // [R1]
    sum_nxt = acc_r + {{10{val_nxt[11] & diff}}, val_nxt};                         // [R8] [R5]
    // Cast keeps the shift arithmetic inside the mixed-sign select
    div_nxt = diff ? $unsigned($signed(acc_r) >>> avg_r[6:4])                    // [R7] [R18]
                   : (acc_r >> avg_r[6:4]);
    if (ctrl_r[`ACC_CTRL_LEFT])
      res_nxt = {div_nxt[11:0], 4'h0};                                           // [R4]
    else
      res_nxt = div_nxt[15:0];                                                   // [R4]
    case (wmode)
      `ACC_WM_ABOVE:   win_nxt = less_fn(window_lower_threshold_r, res_nxt, diff);                 // [R13] [R14]
      `ACC_WM_BELOW:   win_nxt = less_fn(res_nxt, window_upper_threshold_r, diff);                 // [R15] [R14]
      `ACC_WM_INSIDE:  win_nxt = less_fn(window_lower_threshold_r, res_nxt, diff) &
                                 less_fn(res_nxt, window_upper_threshold_r, diff);                // [R14]
      `ACC_WM_OUTSIDE: win_nxt = less_fn(window_upper_threshold_r, res_nxt, diff) &
                                 less_fn(res_nxt, window_lower_threshold_r, diff);                // [R14]
      default:         win_nxt = 1'b0;
    endcase
  end

  // APB slave: one wait-free access phase, answer registered in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      ctrl_s_r  <= 16'h0000;
      avg_s_r   <= 8'h00;
      samp_s_r  <= 8'h00;
      window_lower_threshold_s_r <= 16'h0000;
      window_upper_threshold_s_r <= 16'h0000;
      gain_s_r  <= `ACC_GAIN_RST;
      offs_s_r  <= 12'h000;
    end else begin
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= err_nxt;
        prdata  <= (pwrite || err_nxt) ? 32'h0000_0000 : rd_nxt;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      if (wr_acc && !pslverr) begin
        case (idx)
          `ACC_IDX_CTRL:  ctrl_s_r  <= pwdata[15:0] & `ACC_CTRL_MASK;
          `ACC_IDX_AVG:   avg_s_r   <= pwdata[7:0] & `ACC_AVG_MASK;
          `ACC_IDX_SAMP:  samp_s_r  <= pwdata[7:0] & `ACC_SAMP_MASK;
          `ACC_IDX_WINDOW_LOWER_THRESHOLD: window_lower_threshold_s_r <= pwdata[15:0];
          `ACC_IDX_WINDOW_UPPER_THRESHOLD: window_upper_threshold_s_r <= pwdata[15:0];
          `ACC_IDX_GAIN:  gain_s_r  <= pwdata[11:0];
          `ACC_IDX_OFFS:  offs_s_r  <= pwdata[11:0];
          default:        ctrl_s_r  <= ctrl_s_r;
        endcase
      end
    end
  end

  // Converter clock enable and domain transfer of shadows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r   <= 4'd0;
      tick_r  <= 1'b0;
      sync_r  <= 11'h000;
      ctrl_r  <= 16'h0000;
      avg_r   <= 8'h00;
      samp_r  <= 8'h00;
      window_lower_threshold_r <= 16'h0000;
      window_upper_threshold_r <= 16'h0000;
      gain_r  <= `ACC_GAIN_RST;
      offs_r  <= 12'h000;
    end else begin
      pre_r  <= (pre_r == `ACC_PRESCALE - 4'd1) ? 4'd0 : pre_r + 4'd1;
      tick_r <= (pre_r == `ACC_PRESCALE - 4'd1);
      // A write landing on the transfer tick keeps its flag set
      if (tick_r) begin
        sync_r <= sync_set;                                                      // [R6]
        if (sync_r[`ACC_SB_CTRL])  ctrl_r  <= ctrl_s_r;
        if (sync_r[`ACC_SB_AVG])   avg_r   <= avg_s_r;
        if (sync_r[`ACC_SB_SAMP])  samp_r  <= samp_s_r;
        if (sync_r[`ACC_SB_WINDOW_LOWER_THRESHOLD]) window_lower_threshold_r <= window_lower_threshold_s_r;
        if (sync_r[`ACC_SB_WINDOW_UPPER_THRESHOLD]) window_upper_threshold_r <= window_upper_threshold_s_r;
        if (sync_r[`ACC_SB_GAIN])  gain_r  <= gain_s_r;
        if (sync_r[`ACC_SB_OFFS])  offs_r  <= offs_s_r;
      end else begin
        sync_r <= sync_r | sync_set;                                             // [R6]
      end
    end
  end

  // Conversion sequencer, stepped on converter clock ticks except for the done state, which leaves on the next pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= ST_IDLE;
      cnt_r          <= 6'd0;
      num_r          <= 11'h000;
      acc_r          <= 22'h000000;
      raw_r          <= 12'h000;
      start_r        <= 1'b0;
      result_r       <= 16'h0000;
      sampling_o     <= 1'b0;
      differential_o <= 1'b0;
      result_valid_o <= 1'b0;
      window_hit_o   <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      differential_o <= diff;                                                    // [R5]
      case (st_r)
        ST_IDLE: begin
          if ((start_r || start_trig) && tick_r) begin
            start_r    <= start_r ? 1'b0 : sync_set[`ACC_SB_TRIG];
            st_r       <= ST_SAMP;
            cnt_r      <= samp_last;
            num_r      <= 11'h000;
            acc_r      <= 22'h000000;
            sampling_o <= 1'b1;
          end else if (sync_set[`ACC_SB_TRIG] || start_trig) begin
            start_r <= 1'b1;
          end
        end
        ST_SAMP: begin
          if (tick_r) begin
            if (cnt_r == 6'd0) begin
              st_r       <= ST_CONV;
              cnt_r      <= `ACC_CONV_CYC - 6'd1;
              sampling_o <= 1'b0;
            end else begin
              cnt_r <= cnt_r - 6'd1;                                             // [R12] [R10]
            end
          end
        end
        ST_CONV: begin
          if (tick_r) begin
            if (cnt_r == 6'd0) begin
              raw_r <= conv_data;
              cnt_r <= `ACC_CORR_CYC - 6'd1;
              st_r  <= ctrl_r[`ACC_CTRL_CORR] ? ST_CORR : ST_ACC;                // [R2]
            end else begin
              cnt_r <= cnt_r - 6'd1;
            end
          end
        end
        ST_CORR: begin
          if (tick_r) begin
            if (cnt_r == 6'd0)
              st_r <= ST_ACC;
            else
              cnt_r <= cnt_r - 6'd1;                                             // [R2]
          end
        end
        ST_ACC: begin
          // Waiting for a tick keeps every later sampling phase full length
          if (tick_r) begin
            acc_r <= sum_nxt;                                                    // [R8]
            if (num_r == n_last) begin
              st_r <= ST_DONE;
            end else begin
              num_r      <= num_r + 11'h001;
              cnt_r      <= samp_last;
              st_r       <= ST_SAMP;
              sampling_o <= 1'b1;                                                // [R12]
            end
          end
        end
        ST_DONE: begin
          result_r       <= res_nxt;                                             // [R18]
          window_hit_o   <= win_nxt;                                             // [R13]
          result_valid_o <= 1'b1;
          st_r           <= ST_IDLE;                                             // [R3]
          if (ctrl_r[`ACC_CTRL_FREE])
            start_r <= 1'b1;                                                     // [R3]
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // acc_conv_ctrl

// >>> verification/acc_conv_monitor.sv
// Bus answer and result timing assertions for the converter control
`timescale 1ns/100ps
module acc_conv_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        sampling_o,
  input logic        result_valid_o,
  input logic        window_hit_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  a_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
    else $error("result strobe too long");
  a_sample_min: assert property ($rose(sampling_o) |-> sampling_o [*4])
    else $error("sampling shorter than one tick");
  a_conv_after_sample: assert property ($fell(sampling_o) |-> !result_valid_o [*8])
    else $error("result too soon after sampling");
  a_hit_held: assert property ($changed(window_hit_o) |-> result_valid_o || $past(result_valid_o))
    else $error("window flag moved without a result");
endmodule // acc_conv_monitor
bind acc_conv_ctrl acc_conv_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sampling_o(sampling_o), .result_valid_o(result_valid_o),
  .window_hit_o(window_hit_o));

// >>> verification/tb_acc_conv_ctrl.sv
// Register and conversion sequence testbench for the converter control
`timescale 1ns/100ps
`include "acc_consts.vh"
module tb_acc_conv_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, start_trig, err, samp_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [11:0] conv_data;
  logic        pready, pslverr, sampling_o, differential_o, result_valid_o, window_hit_o;
  int          miscompares, n_compared, scnt, gap, g0, n, nv;
  int          wm [6] = '{0, 1, 1, 2, 3, 4};
  int          wl [6] = '{'h100, 'h100, 'h300, 'h100, 'h100, 'h300};
  int          wu [6] = '{0, 0, 0, 'h150, 'h300, 'h100};
  int          wh [6] = '{0, 1, 0, 0, 1, 1};

  acc_conv_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_trig(start_trig), .conv_data(conv_data),
    .sampling_o(sampling_o), .differential_o(differential_o),
    .result_valid_o(result_valid_o), .window_hit_o(window_hit_o));

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // Length of the last sampling phase and cycles since it ended
  always @(posedge pclk) begin
    samp_q <= sampling_o;
    if (sampling_o) scnt <= samp_q ? scnt + 1 : 1;
    gap <= sampling_o ? 0 : gap + 1;
  end

  task finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Ready is taken at the rising edge, before the slave updates it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] x, input logic [31:0] d);
    apb(1, {x[5:0], 2'b00}, d);
    chk(err, 0);
  endtask

  task rd(input logic [7:0] x, input logic [31:0] e);
    apb(0, {x[5:0], 2'b00}, 0);
    chk(rdat, e);
  endtask

  task cfg(input logic [31:0] c, input logic [31:0] a, input logic [31:0] s);
    int k;
    wr(`ACC_IDX_CTRL, c);
    wr(`ACC_IDX_AVG, a);
    wr(`ACC_IDX_SAMP, s);
    for (k = 0; k < 20; k++) begin
      apb(0, `ACC_IDX_SYNC << 2, 0);
      if (rdat === 32'h0) break;
    end
    chk(rdat, 0);
  endtask

  task wv;
    int k;
    for (k = 0; k < 4000; k++) begin
      @(negedge pclk);
      if (result_valid_o === 1'b1) break;
    end
    chk(result_valid_o, 1);
  endtask

  // Trigger held until sampling starts; between ticks it is latched and taken on the next tick
  task conv(input logic [11:0] raw, input logic [31:0] e);
    int k;
    @(posedge pclk);
    conv_data <= raw;
    start_trig <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge pclk);
      if (sampling_o === 1'b1) break;
    end
    @(posedge pclk);
    start_trig <= 0;
    wv;
    rd(`ACC_IDX_RESULT, e);
  endtask

  initial begin
    #400000;
    miscompares++;
    finish_test;
  end

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start_trig = 0;
    conv_data = 12'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(`ACC_IDX_CTRL, 32'h0);
    rd(`ACC_IDX_AVG, 32'h0);
    rd(`ACC_IDX_SAMP, 32'h0);
    rd(`ACC_IDX_WINDOW_LOWER_THRESHOLD, 32'h0);
    rd(`ACC_IDX_SYNC, 32'h0);
    wr(`ACC_IDX_AVG, 32'hff);
    rd(`ACC_IDX_AVG, 32'h7f);
    apb(0, 8'h31, 0);
    chk(err, 1);
    chk(rdat, 0);
    wr(`ACC_IDX_SAMP, 32'hff);
    rd(`ACC_IDX_SAMP, 32'hbf);
    wr(`ACC_IDX_WINDOW_LOWER_THRESHOLD, 32'hffffffff);
    rd(`ACC_IDX_WINDOW_LOWER_THRESHOLD, 32'hffff);
    wr(`ACC_IDX_CTRL, 32'hffff);
    rd(`ACC_IDX_CTRL, 32'h373f);
    wr(`ACC_IDX_WINDOW_LOWER_THRESHOLD, 32'h0);
    apb(0, 8'h04, 0);
    chk(err, 1);
    chk(rdat, 0);
    cfg(0, 0, 0);
    apb(1, 8'h31, 32'h55);
    chk(err, 1);
    rd(`ACC_IDX_AVG, 32'h0);
    conv(12'h123, 32'h123);
    chk(scnt, 4);
    g0 = gap;
    cfg(0, 0, 5);
    conv(12'h321, 32'h321);
    chk(scnt, 24);
    cfg(0, 0, 32'h80);
    conv(12'h321, 32'h321);
    chk(scnt, 16);
    cfg(2, 0, 0);
    conv(12'habc, 32'habc0);
    cfg(32'h10, 32'h12, 0);
    conv(12'h100, 32'h200);
    cfg(32'h10, 32'h33, 0);
    conv(12'h7ff, 32'h7ff);
    wr(`ACC_IDX_GAIN, 32'h800);
    wr(`ACC_IDX_OFFS, 32'hff0);
    cfg(8, 0, 0);
    conv(12'h100, 32'h110);
    chk(gap - g0, 52);
    wr(`ACC_IDX_GAIN, 32'h400);
    wr(`ACC_IDX_OFFS, 32'h010);
    cfg(8, 0, 0);
    conv(12'h210, 32'h100);
    cfg(32'h11, 32'h11, 0);
    chk(differential_o, 1);
    conv(12'hfff, 32'hffff);
    cfg(1, 32'h70, 0);
    conv(12'h800, 32'hfff0);
    for (n = 0; n < 6; n++) begin
      wr(`ACC_IDX_WINDOW_LOWER_THRESHOLD, wl[n]);
      wr(`ACC_IDX_WINDOW_UPPER_THRESHOLD, wu[n]);
      cfg(wm[n] << 8, 0, 0);
      chk(differential_o, 0);
      conv(12'h200, 32'h200);
      chk(window_hit_o, wh[n]);
    end
    cfg(4, 0, 0);
    wr(`ACC_IDX_TRIG, 32'h2);
    wv;
    wv;
    cfg(0, 0, 0);
    repeat (200) @(posedge pclk);
    nv = 0;
    for (n = 0; n < 300; n++) begin
      @(negedge pclk);
      if (result_valid_o === 1'b1) nv++;
    end
    chk(nv, 0);
    finish_test;
  end
endmodule // tb_acc_conv_ctrl
